// >>> two_wire_memory_slave.sv
// Two-wire bus slave front end of a 512-byte serial memory
`timescale 1ns/1ns
module two_wire_memory_slave #(
  parameter logic [3:0] DEV_TYPE = mem_slave_pkg::DEV_TYPE_DEFAULT
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic dev_select_pin_hi_in,
  input wire logic dev_select_pin_lo_in,
  input wire logic write_protect_in,
  output logic busy_out
);
  // ----------------------------------------------------------------
  // Reset and input synchronisation
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic scl_s, sda_s, sel_hi_s, sel_lo_s, wp_s;
  logic scl_d_reg, sda_d_reg;
  logic scl_rise, scl_fall, start_det, stop_det;

  // Release reset through two flops so it leaves in step with the clock
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  pin_sync u_scl (.clk_in(sys_clk_in), .rst_n_in(rst_n), .pin_in(scl_in), .level_out(scl_s));
  pin_sync u_sda (.clk_in(sys_clk_in), .rst_n_in(rst_n), .pin_in(sda_in), .level_out(sda_s));
  pin_sync u_shi (.clk_in(sys_clk_in), .rst_n_in(rst_n), .pin_in(dev_select_pin_hi_in), .level_out(sel_hi_s));
  pin_sync u_slo (.clk_in(sys_clk_in), .rst_n_in(rst_n), .pin_in(dev_select_pin_lo_in), .level_out(sel_lo_s));
  pin_sync u_wp (.clk_in(sys_clk_in), .rst_n_in(rst_n), .pin_in(write_protect_in), .level_out(wp_s));

  // Previous filtered levels for edge detection
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  mem_slave_pkg::slave_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic ack_phase_reg;
  logic drive_low_reg;
  logic page_reg;
  logic [8:0] addr_reg;
  logic [7:0] tx_reg;
  logic [7:0] mem [0:mem_slave_pkg::MEM_DEPTH-1];
  logic [7:0] byte_full;
  logic addr_match, prot_hit, wr_ok;
  logic [8:0] word_addr, cur_addr;
  // Marks that eight bits arrived and the ack slot is owed
  logic byte_seen_reg;

  // MSB first: the byte fills from the bottom, oldest bit on top
  assign byte_full = {shift_reg[6:0], sda_s};
  assign addr_match = (byte_full[mem_slave_pkg::TYPE_HI:mem_slave_pkg::TYPE_LO] == DEV_TYPE)
                   && (byte_full[mem_slave_pkg::SEL_HI_BIT] == sel_hi_s)
                   && (byte_full[mem_slave_pkg::SEL_LO_BIT] == sel_lo_s);
  // full write address from page and word byte
  assign word_addr = {page_reg, byte_full};
  // read address joins page bit with latched low bits
  assign cur_addr = {page_reg, addr_reg[7:0]};
  // protection covers the upper half; writes use the full latched address
  assign prot_hit = wp_s && addr_reg[mem_slave_pkg::PROT_BIT];
  assign wr_ok = !prot_hit;
  assign busy_out = (state_reg != mem_slave_pkg::ST_IDLE);

  // Bit counter and shifter; ack slot follows the eighth bit
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ack_phase_reg <= 1'b0;
    end else if (start_det || stop_det) begin
      bit_cnt_reg <= 4'h0;
      ack_phase_reg <= 1'b0;
    end else if (scl_rise && !ack_phase_reg) begin
      shift_reg <= byte_full;
      bit_cnt_reg <= (bit_cnt_reg == mem_slave_pkg::BIT_LAST) ? 4'h0 : bit_cnt_reg + 4'h1;
    end else if (scl_fall && bit_cnt_reg == 4'h0 && state_reg != mem_slave_pkg::ST_IDLE
                 && !ack_phase_reg && byte_seen_reg) begin
      ack_phase_reg <= 1'b1;
    end else if (scl_fall && ack_phase_reg) begin
      ack_phase_reg <= 1'b0;
    end
  end

  // Pulses on the rising clock that completes a byte
  logic byte_done;
  assign byte_done = scl_rise && !ack_phase_reg && (bit_cnt_reg == mem_slave_pkg::BIT_LAST);
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      byte_seen_reg <= 1'b0;
    end else if (start_det || stop_det) begin
      byte_seen_reg <= 1'b0;
    end else if (byte_done) begin
      byte_seen_reg <= 1'b1;
    end else if (scl_fall) begin
      byte_seen_reg <= 1'b0;
    end
  end

  // Whether this byte earns an acknowledge from us
  logic ack_give_reg;

  // Transaction state: decided at each completed byte or ack sample
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= mem_slave_pkg::ST_IDLE;
      page_reg <= 1'b0;
      ack_give_reg <= 1'b0;
    end else if (start_det) begin
      // start aborts and awaits an address
      state_reg <= mem_slave_pkg::ST_SLAVE;
      ack_give_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= mem_slave_pkg::ST_IDLE;
      ack_give_reg <= 1'b0;
    end else if (byte_done) begin
      case (state_reg)
        mem_slave_pkg::ST_SLAVE: begin
          if (addr_match) begin
            page_reg <= byte_full[mem_slave_pkg::PAGE_BIT];
            ack_give_reg <= 1'b1;
            state_reg <= (byte_full[mem_slave_pkg::DIR_BIT] == mem_slave_pkg::DIR_READ)
                         ? mem_slave_pkg::ST_RDATA : mem_slave_pkg::ST_WORD;
          end else begin
            // stay quiet until the next start
            ack_give_reg <= 1'b0;
            state_reg <= mem_slave_pkg::ST_IDLE;
          end
        end
        mem_slave_pkg::ST_WORD: begin
          ack_give_reg <= 1'b1;
          state_reg <= mem_slave_pkg::ST_WDATA;
        end
        mem_slave_pkg::ST_WDATA: begin
          ack_give_reg <= wr_ok;
          state_reg <= wr_ok ? mem_slave_pkg::ST_WDATA : mem_slave_pkg::ST_IDLE;
        end
        mem_slave_pkg::ST_RDATA: begin
          ack_give_reg <= 1'b0;
          state_reg <= mem_slave_pkg::ST_RACK;
        end
        default: begin
          ack_give_reg <= 1'b0;
        end
      endcase
    end else if (scl_rise && ack_phase_reg && state_reg == mem_slave_pkg::ST_RACK) begin
      state_reg <= sda_s ? mem_slave_pkg::ST_IDLE : mem_slave_pkg::ST_RDATA;
    end else if (scl_fall && ack_phase_reg) begin
      ack_give_reg <= 1'b0;
    end
  end

  // Address latch and memory array
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= mem_slave_pkg::ADDR_RESET;
    end else if (byte_done && state_reg == mem_slave_pkg::ST_WORD) begin
      // latch full address; kept across a repeated start
      addr_reg <= word_addr;
    end else if (byte_done && state_reg == mem_slave_pkg::ST_WDATA && wr_ok) begin
      // increment before the ack; 9-bit wrap, protected attempts skip this
      addr_reg <= addr_reg + mem_slave_pkg::ADDR_ONE;
    end else if (byte_done && state_reg == mem_slave_pkg::ST_RDATA) begin
      addr_reg <= cur_addr + mem_slave_pkg::ADDR_ONE;
    end
  end

  // array write on the eighth bit, done within one cycle
  always_ff @(posedge sys_clk_in) begin
    if (byte_done && state_reg == mem_slave_pkg::ST_WDATA && wr_ok && !start_det && !stop_det) begin
      mem[addr_reg] <= byte_full;
    end
  end

  // Transmit byte: load at the falling edge that opens a read byte
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tx_reg <= 8'h00;
    end else if (scl_fall && state_reg == mem_slave_pkg::ST_RDATA && bit_cnt_reg == 4'h0 && !byte_seen_reg) begin
      tx_reg <= mem[cur_addr];
    end else if (scl_fall && state_reg == mem_slave_pkg::ST_RDATA && !ack_phase_reg) begin
      tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // SDA driver
  // ----------------------------------------------------------------
  // output changes on falling clock and is released at start or stop; open drain, low only
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      drive_low_reg <= 1'b0;
    end else if (start_det || stop_det) begin
      drive_low_reg <= 1'b0;
    end else if (scl_fall) begin
      if (byte_seen_reg) begin
        drive_low_reg <= ack_give_reg;
      end else if (state_reg == mem_slave_pkg::ST_RDATA && bit_cnt_reg == 4'h0) begin
        // First bit leaves at the fall that closes the ack slot
        drive_low_reg <= !mem[cur_addr][mem_slave_pkg::BYTE_W-1];
      end else if (state_reg == mem_slave_pkg::ST_RDATA && !ack_phase_reg) begin
        drive_low_reg <= !tx_reg[6];
      end else begin
        drive_low_reg <= 1'b0;
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n_out = !drive_low_reg;
endmodule

// >>> mem_slave_pkg.sv
// Constants shared by the two-wire memory slave design
package mem_slave_pkg;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned MEM_DEPTH = 512;
  localparam int unsigned BYTE_W = 8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [8:0] ADDR_RESET = 9'h000;
  localparam logic [8:0] ADDR_ONE = 9'h001;
  localparam int unsigned TYPE_HI = 7;
  localparam int unsigned TYPE_LO = 4;
  localparam int unsigned SEL_HI_BIT = 3;
  localparam int unsigned SEL_LO_BIT = 2;
  localparam int unsigned PAGE_BIT = 1;
  localparam int unsigned DIR_BIT = 0;
  localparam int unsigned PROT_BIT = 8;
  localparam logic DIR_READ = 1'b1;
  localparam logic [2:0] SYNC_RESET = 3'h7;
  // Device type code; value is arbitrary
  localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SLAVE, ST_WORD, ST_WDATA, ST_RDATA, ST_RACK
  } slave_state_t;
endpackage

// >>> pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  output logic level_out
);
  logic [2:0] sync_reg;

  // Stage one feeds only stage two; stages two and three must agree
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_reg <= mem_slave_pkg::SYNC_RESET;
    end else begin
      sync_reg <= {sync_reg[1:0], pin_in};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_out <= 1'b1;
    end else if (sync_reg[1] == sync_reg[2]) begin
      level_out <= sync_reg[2];
    end
  end
endmodule

// >>> tw_slave_asserts.sv
// Concurrent checks on the pins of the two-wire memory slave
`timescale 1ns/1ns
module tw_slave_asserts (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n_out,
  input wire logic dev_select_pin_hi_in,
  input wire logic dev_select_pin_lo_in,
  input wire logic write_protect_in,
  input wire logic busy_out
);
  // ----
  // Pin checks
  // ----
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Master only moves SDA under high SCL for start and stop
  sequence bus_start;
    scl_in && $fell(sda_in);
  endsequence
  sequence bus_stop;
    scl_in && $rose(sda_in);
  endsequence
  a_reset_idle: assert property ($rose(reset_n_in) |-> sda_oe_n_out && !busy_out)
    else $error("slave not idle at reset release");
  a_pull_low_only: assert property (!sda_oe_n_out |-> !sda_out)
    else $error("slave drives SDA high");
  // Pin synchroniser delays SCL, so look back four clocks for the low phase
  a_drive_on_fall: assert property ($changed(sda_oe_n_out) |-> !$past(scl_in, 4))
    else $error("SDA drive changed outside SCL low");
  a_drive_held: assert property ($fell(sda_oe_n_out) |=> !sda_oe_n_out[*3])
    else $error("SDA drive too short");
  a_start_busy: assert property (bus_start |-> ##[2:8] busy_out ##1 busy_out)
    else $error("start not taken");
  a_start_rearms: assert property (bus_start |-> ##8 sda_oe_n_out)
    else $error("slave drives after start");
  a_stop_idle: assert property (bus_stop |-> ##[2:8] !busy_out)
    else $error("stop did not return to idle");
  a_idle_released: assert property (!busy_out |-> sda_oe_n_out)
    else $error("slave drives while idle");
  cover property (bus_start);
  cover property (bus_stop);
  cover property ($fell(sda_oe_n_out));
endmodule
bind two_wire_memory_slave tw_slave_asserts u_chk (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
  .dev_select_pin_hi_in(dev_select_pin_hi_in), .dev_select_pin_lo_in(dev_select_pin_lo_in),
  .write_protect_in(write_protect_in), .busy_out(busy_out));

// >>> tw_master.sv
// Bus master model: SCL at 400 ns, open-drain SDA
`timescale 1ns/1ns
module tw_master (
  input wire logic clk_in,
  input wire logic sda_wire_in,
  output logic scl_out,
  output logic sda_drv_out
);
  // ----
  // Bus phases, moved on falling system clock
  // ----
  initial begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
  end
  task automatic q(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // start, also used as repeated start
  task automatic start();
    q(1);
    sda_drv_out = 1'b1;
    q(5);
    scl_out = 1'b1;
    q(3);
    sda_drv_out = 1'b0;
    q(3);
    scl_out = 1'b0;
  endtask
  // stop, only while master owns SDA
  task automatic stop();
    q(1);
    sda_drv_out = 1'b0;
    q(5);
    scl_out = 1'b1;
    q(3);
    sda_drv_out = 1'b1;
    q(4);
  endtask
  // data set in low phase, sampled at end of high phase
  // Long low phase covers the slave's synchroniser latency before SCL rises
  task automatic bit_io(input logic b, output logic r);
    q(1);
    sda_drv_out = b;
    q(5);
    scl_out = 1'b1;
    q(2);
    r = sda_wire_in;
    scl_out = 1'b0;
  endtask
  // MSB first, ninth bit is acknowledge
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] r, output logic ar);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      r[i] = b;
    end
    bit_io(a, ar);
  endtask
endmodule

// >>> tb.sv
// Self-checking bench for the two-wire memory slave
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  // ----
  // Bench wiring
  // ----
  logic sys_clk, reset_n, scl, sda_drv, sda, sda_out, sda_oe_n, wp, busy, sel_hi, sel_lo, ack;
  logic [7:0] rd;
  int miscompares = 0;
  int samples_checked = 0;
  // Pulled-up open-drain wire
  assign sda = sda_drv & (sda_oe_n | sda_out);
  tw_master m (.clk_in(sys_clk), .sda_wire_in(sda), .scl_out(scl), .sda_drv_out(sda_drv));
  two_wire_memory_slave uut (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n), .dev_select_pin_hi_in(sel_hi),
    .dev_select_pin_lo_in(sel_lo), .write_protect_in(wp), .busy_out(busy));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  function automatic logic [7:0] sa(input logic pg, input logic rw);
    return {mem_slave_pkg::DEV_TYPE_DEFAULT, 1'b1, 1'b0, pg, rw};
  endfunction
  task automatic wr(input logic [7:0] d, input logic exp_ack);
    m.byte_io(d, 1'b1, rd, ack);
    `CHK(ack, exp_ack)
  endtask
  task automatic rdb(input logic [7:0] exp, input logic last);
    m.byte_io(8'hFF, last, rd, ack);
    `CHK(rd, exp)
  endtask
  // Address a write and load the latch with page and word
  task automatic wr_at(input logic pg, input logic [7:0] w);
    m.start();
    wr(sa(pg, 1'b0), 1'b0);
    wr(w, 1'b0);
  endtask
  // Set the latch, then turn round into a read of that page
  task automatic rd_at(input logic pg, input logic [7:0] w);
    wr_at(pg, w);
    m.start();
    wr(sa(pg, 1'b1), 1'b0);
  endtask
  task automatic results();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Whole run is a few thousand clocks; this only cuts a hang
  initial begin
    repeat (30000) @(posedge sys_clk);
    miscompares++;
    results();
  end
  initial begin
    reset_n = 1'b0;
    wp = 1'b0;
    sel_hi = 1'b1;
    sel_lo = 1'b0;
    repeat (12) @(negedge sys_clk);
    `CHK({sda_oe_n, busy, sda_out}, 3'b100)
    reset_n = 1'b1;
    repeat (10) @(negedge sys_clk);
    wr_at(1'b1, 8'hFF);
    wr(8'h11, 1'b0);
    wr(8'h22, 1'b0);
    wr(8'h33, 1'b0);
    `CHK(busy, 1'b1)
    m.stop();
    repeat (4) @(negedge sys_clk);
    `CHK(busy, 1'b0)
    rd_at(1'b0, 8'h00);
    rdb(8'h22, 1'b0);
    rdb(8'h33, 1'b1);
    m.stop();
    rd_at(1'b1, 8'hFF);
    rdb(8'h11, 1'b1);
    m.stop();
    m.start();
    wr(sa(1'b0, 1'b1), 1'b0);
    rdb(8'h22, 1'b1);
    m.stop();
    $display("wrap and sequential done");
    for (int i = 0; i < 3; i++) begin
      m.start();
      wr(sa(1'b0, 1'b0) ^ (8'h04 << i), 1'b1);
      m.bit_io(1'b1, ack);
      `CHK(ack, 1'b1)
      m.stop();
    end
    $display("address decode done");
    wr_at(1'b1, 8'h10);
    wr(8'h44, 1'b0);
    m.stop();
    wp = 1'b1;
    wr_at(1'b1, 8'h10);
    wr(8'h99, 1'b1);
    m.stop();
    m.start();
    wr(sa(1'b1, 1'b1), 1'b0);
    rdb(8'h44, 1'b1);
    m.stop();
    wr_at(1'b0, 8'h10);
    wr(8'h77, 1'b0);
    m.stop();
    wp = 1'b0;
    $display("write protect done");
    wr_at(1'b0, 8'h10);
    for (int i = 0; i < 5; i++) begin
      m.bit_io(1'b0, ack);
    end
    m.stop();
    wr_at(1'b0, 8'h10);
    for (int i = 0; i < 3; i++) begin
      m.bit_io(1'b0, ack);
    end
    m.start();
    wr(sa(1'b0, 1'b1), 1'b0);
    rdb(8'h77, 1'b1);
    m.stop();
    reset_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (10) @(negedge sys_clk);
    m.start();
    wr(sa(1'b0, 1'b1), 1'b0);
    rdb(8'h22, 1'b1);
    m.stop();
    $display("abort and reset done");
    results();
  end
endmodule
